// ### dv/bsc_far_end.sv
// far end model: receive stream with reference, transmit bit slots
`timescale 1ns/100ps
module bsc_far_end (
  input  wire logic clk_in,
  input  wire logic rx_en_in,
  input  wire logic err_in,
  input  wire logic tx_en_in,
  output logic      rx_bit_valid_out = 1'b0,
  output logic      rx_data_out = 1'b0,
  output logic      rx_ref_bit_out = 1'b0,
  output logic      tx_bit_valid_out = 1'b0,
  output logic      tx_data_out = 1'b0
);
  logic [6:0] lfsr_q = 7'h5A;
  logic [1:0] slot_q = 2'h0;
  always_ff @(posedge clk_in) begin
    rx_bit_valid_out <= rx_en_in;
    if (rx_en_in) begin
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
      rx_ref_bit_out <= lfsr_q[6];
      rx_data_out <= lfsr_q[6] ^ err_in;
    end else begin
      // idle line wanders so a stale bit never looks valid
      rx_data_out <= ~rx_data_out;
    end
  end
  always_ff @(posedge clk_in) begin
    slot_q <= slot_q + 2'h1;
    tx_bit_valid_out <= tx_en_in && slot_q == 2'h0;
    tx_data_out <= ~tx_data_out ^ slot_q[1];
  end
endmodule // bsc_far_end

// ### dv/bsc_top_asserts.sv
// port assertions for the status and counter block
`timescale 1ns/100ps
module bsc_top_asserts
  import bsc_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic              rd_in,
  input wire logic              wr_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic              local_update_request_in,
  input wire logic              update_source_select_in,
  input wire logic              tx_data_in,
  input wire logic              tx_bit_valid_out,
  input wire logic              tx_data_out,
  input wire logic              irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  wire logic rd_st = rd_in && addr_in == STATUS_ADDR;
  logic      txd_prev_q;
  logic      flip_seen_q;
  wire logic inv_slot = tx_bit_valid_out && (tx_data_out != txd_prev_q);

  // one inversion per trigger; any control write rearms
  always_ff @(posedge clk_in) begin
    txd_prev_q <= tx_data_in;
    if (!resetn_in || (wr_in && addr_in == TX_ERR_CTRL_ADDR)) begin
      flip_seen_q <= 1'b0;
    end else if (inv_slot) begin
      flip_seen_q <= 1'b1;
    end
  end

  rst_quiet_a: assert property ($rose(resetn_in) |-> !irq_out && rdata_out == 8'h00)
    else $error("outputs not quiet after reset");
  unmapped_read_a: assert property (rd_in && !(addr_in inside {8'hE8, 8'hEC, 8'hEE, 8'hF0,
    [8'hF4:8'hF6], [8'hF8:8'hFB]}) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  ctrl_bits_a: assert property (rd_in && addr_in == TX_ERR_CTRL_ADDR |=>
    rdata_out[0] == 1'b0 && rdata_out[7:6] == 2'b00)
    else $error("unused control bits not zero");
  rdata_hold_a: assert property (!rd_in |=> $stable(rdata_out))
    else $error("read data moved without read");
  reset_status_a: assert property ($rose(resetn_in) ##1 rd_st |=> rdata_out == 8'h01)
    else $error("status after reset wrong");
  update_clear_a: assert property (rd_st && !update_source_select_in
    && !local_update_request_in |=> !rdata_out[ST_UPD_BIT])
    else $error("update flag not cleared");
  single_flip_a: assert property (inv_slot |-> !flip_seen_q)
    else $error("two inverted bits for one trigger");
  flip_slot_a: assert property (!tx_bit_valid_out |-> $stable(tx_data_out))
    else $error("transmit data moved outside a bit slot");
endmodule // bsc_top_asserts

bind bsc_top bsc_top_asserts chk_u (.clk_in(clk_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .rd_in(rd_in), .wr_in(wr_in), .rdata_out(rdata_out),
  .tx_data_in(tx_data_in),
  .local_update_request_in(local_update_request_in), .irq_out(irq_out),
  .update_source_select_in(update_source_select_in), .tx_data_out(tx_data_out),
  .tx_bit_valid_out(tx_bit_valid_out));

// ### dv/bsc_top_tb.sv
// self-checking bench for the status and counter block
`timescale 1ns/100ps
module bsc_top_tb;
  import bsc_pkg::*;
  logic              clk_in = 1'b0;
  logic              resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = 8'h00;
  logic [DATA_W-1:0] wdata_in = 8'h00;
  logic [DATA_W-1:0] rdata_out;
  logic              wr_in = 1'b0, rd_in = 1'b0, man = 1'b0, loc = 1'b0, sel = 1'b0;
  logic              ext = 1'b0, rx_en = 1'b0, err = 1'b0, tx_en = 1'b1, txd_d = 1'b0;
  logic              rxv, rxd, rxr, txv, txd, txv_o, txd_o, irq_out;
  logic              ard = 1'b0;
  int                err_total = 0, comparisons = 0, flips = 0;

  initial forever #50 clk_in = ~clk_in;

  bsc_top dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .manual_insert_mode_select_in(man), .auto_resync_disable_in(ard),
    .local_update_request_in(loc), .update_source_select_in(sel),
    .external_update_request_in(ext), .resync_in(1'b0), .rx_bit_valid_in(rxv),
    .rx_data_in(rxd), .rx_ref_bit_in(rxr), .tx_bit_valid_in(txv), .tx_data_in(txd),
    .tx_bit_valid_out(txv_o), .tx_data_out(txd_o), .irq_out(irq_out));
  bsc_far_end far_u (.clk_in(clk_in), .rx_en_in(rx_en), .err_in(err), .tx_en_in(tx_en),
    .rx_bit_valid_out(rxv), .rx_data_out(rxd), .rx_ref_bit_out(rxr),
    .tx_bit_valid_out(txv), .tx_data_out(txd));

  // inverted transmit bits seen in a slot
  always @(posedge clk_in) begin
    if (txv_o === 1'b1 && txd_o !== txd_d) flips++;
    txd_d <= txd;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    wr_in = 1'b1;
    addr_in = a;
    wdata_in = d;
    tick(1);
    wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    rd_in = 1'b1;
    addr_in = a;
    tick(1);
    rd_in = 1'b0;
    d = rdata_out;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(d, e);
  endtask
  task automatic send(input int n, input logic [31:0] m);
    for (int i = 0; i < n; i++) begin
      tick(1);
      rx_en = 1'b1;
      err = (i < 32) && m[i];
    end
    tick(1);
    rx_en = 1'b0;
    err = 1'b0;
  endtask
  // snapshot through local bit or external pin, then release
  task automatic snap(input logic s);
    logic [7:0] d;
    tick(1);
    sel = s;
    loc = !s;
    ext = s;
    tick(6);
    rd(STATUS_ADDR, d);
    chk8(d & 8'h08, 8'h08);
    loc = 1'b0;
    ext = 1'b0;
    tick(6);
    rd(STATUS_ADDR, d);
    chk8(d & 8'h08, 8'h00);
  endtask
  task automatic tally(input logic [7:0] base, input int n, input logic [31:0] e);
    logic [31:0] v;
    logic [7:0] d;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      rd(base + 8'(i), d);
      v[8*i +: 8] = d;
    end
    chk32(v, e);
  endtask

  task automatic t_regs();
    logic [7:0] a [10] = '{8'hEC, 8'hE8, 8'hED, 8'hEE, 8'hF0, 8'hF4, 8'hF6, 8'hF7,
      8'hF8, 8'hFB};
    for (int i = 0; i < 10; i++) rdchk(a[i], (i == 0) ? 8'h01 : 8'h00);
    wr(ERR_TALLY_B0_ADDR, 8'hFF);
    rdchk(ERR_TALLY_B0_ADDR, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h0F);
    rdchk(IRQ_ENABLE_ADDR, 8'h0F);
    wr(IRQ_ENABLE_ADDR, 8'h00);
  endtask

  task automatic t_rx();
    logic [7:0] d;
    send(40, 32'h0);
    rdchk(STATUS_ADDR, 8'h00);
    snap(1'b0);
    wr(STATUS_LATCH_ADDR, 8'h0F);
    rdchk(STATUS_LATCH_ADDR, 8'h00);
    send(20, 32'h0000_8204);
    rdchk(STATUS_ADDR, 8'h02);
    snap(1'b1);
    tally(ERR_TALLY_B0_ADDR, 3, 32'd3);
    tally(BIT_TALLY_B0_ADDR, 4, 32'd20);
    rdchk(STATUS_LATCH_ADDR, 8'h0E);
    wr(STATUS_LATCH_ADDR, 8'h00);
    rdchk(STATUS_LATCH_ADDR, 8'h0E);
    wr(IRQ_ENABLE_ADDR, 8'h01);
    chk8({7'h0, irq_out}, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h04);
    chk8({7'h0, irq_out}, 8'h01);
    wr(STATUS_LATCH_ADDR, 8'h04);
    chk8({7'h0, irq_out}, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h0A);
    chk8({7'h0, irq_out}, 8'h01);
    wr(STATUS_LATCH_ADDR, 8'h0F);
    chk8({7'h0, irq_out}, 8'h00);
    send(8, 32'h3F);
    rd(STATUS_ADDR, d);
    chk8(d & 8'h01, 8'h01);
    rd(STATUS_LATCH_ADDR, d);
    chk8(d & 8'h01, 8'h01);
    snap(1'b0);
    tally(ERR_TALLY_B0_ADDR, 3, 32'd3);
    tally(BIT_TALLY_B0_ADDR, 4, 32'd3);
    send(10, 32'h3FF);
    snap(1'b0);
    tally(ERR_TALLY_B0_ADDR, 3, 32'd0);
    tally(BIT_TALLY_B0_ADDR, 4, 32'd0);
    ard = 1'b1;
    send(40, 32'h0);
    send(8, 32'hFF);
    rd(STATUS_ADDR, d);
    chk8(d & 8'h01, 8'h00);
    ard = 1'b0;
    send(1, 32'h1);
    rd(STATUS_ADDR, d);
    chk8(d & 8'h01, 8'h01);
  endtask

  task automatic t_tx();
    wr(TX_ERR_CTRL_ADDR, 8'h02);
    tick(20);
    chk32(flips, 0);
    wr(TX_ERR_CTRL_ADDR, 8'h00);
    wr(TX_ERR_CTRL_ADDR, 8'h06);
    tick(20);
    chk32(flips, 1);
    rdchk(TX_ERR_CTRL_ADDR, 8'h06);
    tx_en = 1'b0;
    tick(4);
    for (int i = 0; i < 4; i++) wr(TX_ERR_CTRL_ADDR, i[0] ? 8'h06 : 8'h00);
    tx_en = 1'b1;
    tick(20);
    chk32(flips, 2);
    man = 1'b1;
    wr(TX_ERR_CTRL_ADDR, 8'h00);
    wr(TX_ERR_CTRL_ADDR, 8'h06);
    tick(20);
    chk32(flips, 2);
  endtask

  task automatic final_report();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    tick(8);
    resetn_in = 1'b1;
    t_regs();
    t_rx();
    t_tx();
    final_report();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    final_report();
  end
endmodule // bsc_top_tb

// ### verilog/bsc_lock_checker.sv
// receive compare: lock acquisition, windowed loss of lock, error pulse
`timescale 1ns/100ps
module bsc_lock_checker
  import bsc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic bit_valid_in,
  input  wire logic rx_data_in,
  input  wire logic ref_bit_in,
  input  wire logic resync_in,
  input  wire logic auto_resync_disable_in,
  output logic      out_of_lock_out,
  output logic      bit_error_out
);
  localparam logic [5:0] WIN_LAST  = 6'(WINDOW_BITS - 1);
  localparam logic [2:0] DROP_CNT  = 3'(DROP_MISMATCH);
  localparam logic [5:0] LOCK_CNT  = 6'(LOCK_MATCHES);

  bsc_lock_state_t state_q;
  logic [5:0]      win_pos_q;
  logic [2:0]      miss_q;
  logic [5:0]      run_q;
  logic            mismatch;
  logic            drop;

  assign mismatch = bit_valid_in && (rx_data_in != ref_bit_in);
  assign drop = !auto_resync_disable_in && mismatch && (miss_q >= DROP_CNT - 3'(1));

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= BSC_HUNT;
    end else begin
      case (state_q)
        BSC_HUNT: begin
          if (!resync_in && bit_valid_in && !mismatch && (run_q == LOCK_CNT - 6'(1))) begin
            state_q <= BSC_SYNC;
          end
        end
        BSC_SYNC: begin
          if (resync_in || (state_q == BSC_SYNC && drop)) begin
            state_q <= BSC_HUNT;
          end
        end
        default: state_q <= BSC_HUNT;
      endcase
    end
  end

  // run of matching bits while hunting
  always_ff @(posedge clk_in) begin
    if (!resetn_in || resync_in || state_q == BSC_SYNC) begin
      run_q <= '0;
    end else if (bit_valid_in) begin
      run_q <= mismatch ? 6'h00 : run_q + 6'(1);
    end
  end

  // miss count within the current 64-bit window
  always_ff @(posedge clk_in) begin
    if (!resetn_in || state_q != BSC_SYNC || resync_in) begin
      win_pos_q <= '0;
      miss_q    <= '0;
    end else if (bit_valid_in) begin
      win_pos_q <= win_pos_q + 6'(1);
      if (win_pos_q == WIN_LAST) begin
        miss_q <= '0;
      end else if (mismatch && miss_q != DROP_CNT) begin
        miss_q <= miss_q + 3'(1);
      end
    end
  end

  assign out_of_lock_out = (state_q != BSC_SYNC);
  assign bit_error_out   = mismatch && (state_q == BSC_SYNC);
endmodule // bsc_lock_checker

// ### verilog/bsc_pkg.sv
// constants and types shared by the pattern checker status and counter block
package bsc_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ERR_TALLY_W  = 24;
  localparam int unsigned BIT_TALLY_W  = 32;

  // register offsets
  localparam logic [7:0] TX_ERR_CTRL_ADDR   = 8'hE8;
  localparam logic [7:0] STATUS_ADDR        = 8'hEC;
  localparam logic [7:0] STATUS_LATCH_ADDR  = 8'hEE;
  localparam logic [7:0] IRQ_ENABLE_ADDR    = 8'hF0;
  localparam logic [7:0] ERR_TALLY_B0_ADDR  = 8'hF4;
  localparam logic [7:0] ERR_TALLY_B1_ADDR  = 8'hF5;
  localparam logic [7:0] ERR_TALLY_B2_ADDR  = 8'hF6;
  localparam logic [7:0] BIT_TALLY_B0_ADDR  = 8'hF8;
  localparam logic [7:0] BIT_TALLY_B1_ADDR  = 8'hF9;
  localparam logic [7:0] BIT_TALLY_B2_ADDR  = 8'hFA;
  localparam logic [7:0] BIT_TALLY_B3_ADDR  = 8'hFB;

  // transmit error control fields
  localparam int unsigned TRIG_BIT       = 1;
  localparam int unsigned INS_EN_BIT     = 2;
  localparam logic [7:0]  TX_CTRL_WMASK  = 8'h3E;

  // status and latched status field positions
  localparam int unsigned ST_LOCK_BIT    = 0;
  localparam int unsigned ST_NZ_BIT      = 1;
  localparam int unsigned ST_ERR_BIT     = 2;
  localparam int unsigned ST_UPD_BIT     = 3;
  localparam logic [3:0]  STATUS_RESET   = 4'h0;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // lock checker figures
  localparam int unsigned WINDOW_BITS    = 64;
  localparam int unsigned DROP_MISMATCH  = 6;
  localparam int unsigned LOCK_MATCHES   = 32;

  typedef enum logic [1:0] {
    BSC_HUNT = 2'b01,
    BSC_SYNC = 2'b10
  } bsc_lock_state_t;
endpackage

// ### verilog/bsc_sat_counter.sv
// saturating counter with a clear that still honours a same-cycle increment
`timescale 1ns/100ps
module bsc_sat_counter #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         clear_in,
  input  wire logic         inc_in,
  output logic [W-1:0]      count_out
);
  logic [W-1:0] count_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else if (clear_in) begin
      // snapshot takes the old count; this cycle's event opens the new one
      count_q <= inc_in ? W'(1) : '0;
    end else if (inc_in && (count_q != {W{1'b1}})) begin
      count_q <= count_q + W'(1);
    end
  end

  assign count_out = count_q;
endmodule // bsc_sat_counter

// ### verilog/bsc_top.sv
// pattern checker status, latched flags, irq enables, tallies, single error insert
`timescale 1ns/100ps

module bsc_top
  import bsc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // host register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  // control bits held outside this block
  input  wire logic              manual_insert_mode_select_in,
  input  wire logic              auto_resync_disable_in,
  input  wire logic              local_update_request_in,
  input  wire logic              update_source_select_in,
  input  wire logic              external_update_request_in,
  input  wire logic              resync_in,
  // receive stream
  input  wire logic              rx_bit_valid_in,
  input  wire logic              rx_data_in,
  input  wire logic              rx_ref_bit_in,
  // transmit stream and interrupt
  input  wire logic              tx_bit_valid_in,
  input  wire logic              tx_data_in,
  output logic                   tx_bit_valid_out,
  output logic                   tx_data_out,
  output logic                   irq_out
);

  // registers
  logic [7:0]             tx_ctrl_q;
  logic [3:0]             latched_q;
  logic [3:0]             irq_en_q;
  logic [ERR_TALLY_W-1:0] err_snap_q;
  logic [BIT_TALLY_W-1:0] bit_snap_q;
  logic                   update_done_q;
  logic                   snap_pend_q;
  logic                   req_prev_q;
  logic                   ext_req_meta_q;
  logic                   ext_req_sync_q;
  logic                   insert_pend_q;
  logic                   lock_prev_q;
  logic                   nz_prev_q;
  logic                   done_prev_q;
  logic [DATA_W-1:0]      rdata_q;
  logic                   tx_valid_q;
  logic                   tx_data_q;

  // combinational
  logic [ERR_TALLY_W-1:0] err_live;
  logic [BIT_TALLY_W-1:0] bit_live;
  logic                   out_of_lock;
  logic                   bit_error;
  logic                   update_req;
  logic                   update_done;
  logic                   req_rise;
  logic                   nonzero_error_flag;
  logic [3:0]             status;
  logic [3:0]             latch_set;
  logic [3:0]             latch_clr;
  logic                   trig_edge;
  logic                   trig_allowed;
  logic                   trig_rise;
  logic                   wr_tx_ctrl;
  logic [7:0]             tx_ctrl_wr;
  logic [DATA_W-1:0]      rd_mux;

  // select byte k of a wide tally
  function automatic logic [7:0] tally_byte(input logic [BIT_TALLY_W-1:0] v,
                                            input int unsigned k);
    tally_byte = v[k*8 +: 8];
  endfunction

  // register hit test
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  bsc_lock_checker u_lock (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .bit_valid_in           (rx_bit_valid_in),
    .rx_data_in             (rx_data_in),
    .ref_bit_in             (rx_ref_bit_in),
    .resync_in              (resync_in),
    .auto_resync_disable_in (auto_resync_disable_in),
    .out_of_lock_out        (out_of_lock),
    .bit_error_out          (bit_error)
  );

  // saturating error tally, held while unlocked
  bsc_sat_counter #(.W(ERR_TALLY_W)) u_err_tally (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (snap_pend_q),
    .inc_in    (bit_error && !out_of_lock),
    .count_out (err_live)
  );

  // saturating bit tally, held while unlocked
  bsc_sat_counter #(.W(BIT_TALLY_W)) u_bit_tally (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (snap_pend_q),
    .inc_in    (rx_bit_valid_in && !out_of_lock),
    .count_out (bit_live)
  );

  // external update pin is asynchronous to clk_in
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ext_req_meta_q <= 1'b0;
      ext_req_sync_q <= 1'b0;
    end else begin
      ext_req_meta_q <= external_update_request_in;
      ext_req_sync_q <= ext_req_meta_q;
    end
  end

  // selected request; the pin path lags two cycles
  assign update_req = update_source_select_in ? ext_req_sync_q : local_update_request_in;
  assign req_rise   = update_req && !req_prev_q;

  // request low forces the flag low at once
  assign update_done = update_done_q && update_req;

  // request edge history
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      req_prev_q  <= 1'b0;
      snap_pend_q <= 1'b0;
    end else begin
      req_prev_q  <= update_req;
      snap_pend_q <= req_rise;
    end
  end

  // snapshot: request rise copies live tallies one cycle later
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      err_snap_q <= '0;
      bit_snap_q <= '0;
    end else if (snap_pend_q) begin
      err_snap_q <= err_live;
      bit_snap_q <= bit_live;
    end
  end

  // update done flag
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      update_done_q <= 1'b0;
    end else if (!update_req) begin
      update_done_q <= 1'b0;
    end else if (snap_pend_q) begin
      update_done_q <= 1'b1;
    end
  end

  // nonzero follows the live error tally
  assign nonzero_error_flag = (err_live != '0);

  always_comb begin
    status               = STATUS_RESET;
    status[ST_LOCK_BIT]  = out_of_lock;
    status[ST_NZ_BIT]    = nonzero_error_flag;
    // done, gated by the live request
    status[ST_UPD_BIT]   = update_done;
  end

  // edge history; lock starts high so reset gives no false change
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      lock_prev_q <= 1'b1;
      nz_prev_q   <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= out_of_lock;
      nz_prev_q   <= nonzero_error_flag;
      done_prev_q <= update_done;
    end
  end

  always_comb begin
    latch_set              = 4'h0;
    latch_set[ST_UPD_BIT]  = update_done && !done_prev_q;
    latch_set[ST_ERR_BIT]  = bit_error;
    latch_set[ST_NZ_BIT]   = nonzero_error_flag && !nz_prev_q;
    latch_set[ST_LOCK_BIT] = out_of_lock != lock_prev_q;
  end

  // write one to a latched bit clears it
  assign latch_clr = (wr_in && hit(addr_in, STATUS_LATCH_ADDR)) ? wdata_in[3:0] : 4'h0;

  // write one clears, new event wins
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      latched_q <= STATUS_RESET;
    end else begin
      latched_q <= (latched_q & ~latch_clr) | latch_set;
    end
  end

  // irq enables: plain read and write, upper bits read zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_en_q <= STATUS_RESET;
    end else if (wr_in && hit(addr_in, IRQ_ENABLE_ADDR)) begin
      irq_en_q <= wdata_in[3:0];
    end
  end

  assign irq_out = |(latched_q & irq_en_q);

  // unused bit zero is never stored
  assign wr_tx_ctrl = wr_in && hit(addr_in, TX_ERR_CTRL_ADDR);
  assign tx_ctrl_wr = wdata_in & TX_CTRL_WMASK;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_ctrl_q <= REG_RESET;
    end else if (wr_tx_ctrl) begin
      tx_ctrl_q <= tx_ctrl_wr;
    end
  end

  // insertion gated by enable and mode
  assign trig_allowed = tx_ctrl_wr[INS_EN_BIT] && !manual_insert_mode_select_in;
  // zero to one of the trigger bit
  assign trig_edge    = wr_tx_ctrl && tx_ctrl_wr[TRIG_BIT] && !tx_ctrl_q[TRIG_BIT];
  assign trig_rise    = trig_edge && trig_allowed;

  // pending is one bit, extra rises merge
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      insert_pend_q <= 1'b0;
    end else if (trig_rise) begin
      insert_pend_q <= 1'b1;
    end else if (tx_bit_valid_in) begin
      insert_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= tx_bit_valid_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_data_q <= 1'b0;
    end else if (tx_bit_valid_in) begin
      tx_data_q <= tx_data_in ^ insert_pend_q;
    end
  end

  assign tx_bit_valid_out = tx_valid_q;
  assign tx_data_out      = tx_data_q;

  // byte lanes, LSB at lowest offset
  always_comb begin
    rd_mux = REG_RESET;
    if (hit(addr_in, TX_ERR_CTRL_ADDR)) begin
      rd_mux = tx_ctrl_q;
    end else if (hit(addr_in, STATUS_ADDR)) begin
      rd_mux = {4'h0, status};
    end else if (hit(addr_in, STATUS_LATCH_ADDR)) begin
      rd_mux = {4'h0, latched_q};
    end else if (hit(addr_in, IRQ_ENABLE_ADDR)) begin
      rd_mux = {4'h0, irq_en_q};
    end else if (hit(addr_in, ERR_TALLY_B0_ADDR)) begin
      rd_mux = tally_byte(BIT_TALLY_W'(err_snap_q), 0);
    end else if (hit(addr_in, ERR_TALLY_B1_ADDR)) begin
      rd_mux = tally_byte(BIT_TALLY_W'(err_snap_q), 1);
    end else if (hit(addr_in, ERR_TALLY_B2_ADDR)) begin
      rd_mux = tally_byte(BIT_TALLY_W'(err_snap_q), 2);
    end else if (hit(addr_in, BIT_TALLY_B0_ADDR)) begin
      rd_mux = tally_byte(bit_snap_q, 0);
    end else if (hit(addr_in, BIT_TALLY_B1_ADDR)) begin
      rd_mux = tally_byte(bit_snap_q, 1);
    end else if (hit(addr_in, BIT_TALLY_B2_ADDR)) begin
      rd_mux = tally_byte(bit_snap_q, 2);
    end else if (hit(addr_in, BIT_TALLY_B3_ADDR)) begin
      rd_mux = tally_byte(bit_snap_q, 3);
    end
  end

  // read data held until the next read; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_q <= REG_RESET;
    end else if (rd_in) begin
      rdata_q <= rd_mux;
    end
  end

  assign rdata_out = rdata_q;
endmodule // bsc_top
